// *** hdl/pin_sync.sv ***
// Two-flop synchroniser for a pin entering the system clock domain.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/10ps
module pin_sync (
   input wire logic sys_clk_i, // System clock.
   input wire logic resetn_i, // Asynchronous reset, active low.
   input wire logic pin_i, // Raw pin level.
   output logic level_o // Synchronised level.
);
   logic [1:0] stage_reg;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage_reg <= 2'h0;
      end else begin
         stage_reg <= {stage_reg[0], pin_i};
      end
   end
   assign level_o = stage_reg[1];
endmodule

// *** hdl/synth_serial_load_phase_resync.sv ***
// Serial programming port with phase resync timer.
// Assumes serial pins are asynchronous and far slower than sys_clk_i, and
// that the detector reference arrives as a pin that is also oversampled.
`timescale 1ns/10ps
module synth_serial_load_phase_resync #(
   parameter int WORD_W = synth_serial_pkg::WORD_W
) (
   input wire logic sys_clk_i, // System clock, 100 MHz.
   input wire logic resetn_i, // Asynchronous reset, active low.
   input wire logic serial_clk_i, // Serial shift clock pin.
   input wire logic serial_data_i, // Serial data pin.
   input wire logic load_strobe_i, // Load strobe pin.
   input wire logic ref_clk_i, // Phase-detector reference pin.
   output logic [WORD_W-1:0] frac_word_o, // Latch 0 contents.
   output logic [WORD_W-1:0] div_word_o, // Latch 1 contents.
   output logic [WORD_W-1:0] ctrl_word_o, // Latch 2 contents.
   output logic [WORD_W-1:0] ref_word_o, // Latch 3 contents.
   output logic [11:0] fraction_denominator_o, // Stored denominator.
   output logic [11:0] realign_mult_o, // Stored realign interval multiplier.
   output logic [3:0] realign_count_o, // Realign count field.
   output logic sync_pulse_o, // One-cycle sync pulse.
   output logic realign_pulse_o // One-cycle pulse that realigns phase.
);
   typedef enum logic [2:0] {
      ARM_IDLE = 3'b001,
      ARM_WAIT1 = 3'b010,
      ARM_WAIT2 = 3'b100
   } arm_state_t;

   typedef struct packed {
      logic sclk_prev;
      logic strobe_prev;
      logic ref_prev;
      logic [WORD_W-1:0] shift;
      logic [WORD_W-1:0] frac_word;
      logic [WORD_W-1:0] div_word;
      logic [WORD_W-1:0] ctrl_word;
      logic [WORD_W-1:0] ref_word;
      logic [11:0] denom;
      logic [11:0] mult;
      logic [3:0] count_sel;
      logic [11:0] mult_cnt;
      logic [3:0] outer_cnt;
      logic sync_pulse;
      logic realign_pulse;
      arm_state_t arm;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic sclk_s;
   logic sdata_s;
   logic strobe_s;
   logic ref_s;

   // Both routes of the divider latch take the same bit field.
   function automatic logic [11:0] div_field(input logic [WORD_W-1:0] w);
      return w[synth_serial_pkg::DIV_LSB +: synth_serial_pkg::DIV_W];
   endfunction

   // Terminal test shared by both timer stages; a limit of zero behaves as one.
   function automatic logic at_limit(input logic [11:0] cnt, input logic [11:0] lim);
      return (cnt + 12'h001) >= lim;
   endfunction

   // Each pin passes two flops; edges are then found against a one-cycle-old copy.
   pin_sync u_sync_sclk (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i(serial_clk_i),
      .level_o(sclk_s)
   );
   pin_sync u_sync_sdata (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i(serial_data_i),
      .level_o(sdata_s)
   );
   pin_sync u_sync_strobe (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i(load_strobe_i),
      .level_o(strobe_s)
   );
   pin_sync u_sync_ref (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i(ref_clk_i),
      .level_o(ref_s)
   );

   always_comb begin
      logic sclk_rise;
      logic strobe_rise;
      logic ref_rise;
      logic new_freq;
      logic tick;
      logic [WORD_W-1:0] word;
      sclk_rise = 1'b0;
      strobe_rise = 1'b0;
      ref_rise = 1'b0;
      new_freq = 1'b0;
      tick = 1'b0;
      word = '0;
      state_next = state_reg;
      state_next.sync_pulse = 1'b0;
      state_next.realign_pulse = 1'b0;
      state_next.sclk_prev = sclk_s;
      state_next.strobe_prev = strobe_s;
      state_next.ref_prev = ref_s;
      sclk_rise = sclk_s && !state_reg.sclk_prev;
      strobe_rise = strobe_s && !state_reg.strobe_prev;
      ref_rise = ref_s && !state_reg.ref_prev;

      // Shifting only while the strobe is low keeps a stray edge from corrupting the word.
      if (sclk_rise && !strobe_s) begin
         state_next.shift = {state_reg.shift[WORD_W-2:0], sdata_s};
      end

      // Only the last 24 bits shifted count; a frame has no length check.
      if (strobe_rise) begin
         word = state_reg.shift;
         unique case (word[synth_serial_pkg::ADDR_W-1:0])
            synth_serial_pkg::ADDR_FRAC: begin
               state_next.frac_word = word;
               new_freq = 1'b1;
            end
            synth_serial_pkg::ADDR_DIV: begin
               state_next.div_word = word;
               // The load control bit picks multiplier or denominator for the field.
               if (word[synth_serial_pkg::LOAD_CTRL_BIT]) begin
                  state_next.mult = div_field(word);
               end else begin
                  state_next.denom = div_field(word);
               end
            end
            synth_serial_pkg::ADDR_CTRL: begin
               state_next.ctrl_word = word;
               state_next.count_sel =
                  word[synth_serial_pkg::RESYNC_LSB +: synth_serial_pkg::RESYNC_W];
            end
            synth_serial_pkg::ADDR_REF: begin
               state_next.ref_word = word;
            end
         endcase
      end

      if (state_next.count_sel == synth_serial_pkg::RESYNC_RESET) begin
         // Disabled: timer held clear and arming dropped.
         state_next.mult_cnt = '0;
         state_next.outer_cnt = '0;
         state_next.arm = ARM_IDLE;
      end else if (new_freq) begin
         // A reference edge in the load cycle is dropped; the timer restarts anyway.
         state_next.mult_cnt = '0;
         state_next.outer_cnt = '0;
         state_next.arm = ARM_WAIT1;
      end else if (ref_rise) begin
         // A multiplier of zero behaves as one so the timer never stalls.
         if (at_limit(state_reg.mult_cnt, state_reg.mult)) begin
            state_next.mult_cnt = '0;
            if (at_limit(12'(state_reg.outer_cnt), 12'(state_reg.count_sel))) begin
               state_next.outer_cnt = '0;
               tick = 1'b1;
            end else begin
               state_next.outer_cnt = state_reg.outer_cnt + 4'h1;
            end
         end else begin
            state_next.mult_cnt = state_reg.mult_cnt + 12'h001;
         end
      end

      // The second tick after a fraction latch load is the one that realigns the phase.
      if (tick) begin
         state_next.sync_pulse = 1'b1;
         unique case (state_reg.arm)
            ARM_IDLE: state_next.arm = ARM_IDLE;
            ARM_WAIT1: state_next.arm = ARM_WAIT2;
            ARM_WAIT2: begin
               state_next.arm = ARM_IDLE;
               state_next.realign_pulse = 1'b1;
            end
            default: state_next.arm = ARM_IDLE;
         endcase
      end
   end

   // One register holds all state; every output below is a bit of it.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= '0;
         state_reg.arm <= ARM_IDLE;
         state_reg.denom <= synth_serial_pkg::DIV_RESET;
         state_reg.count_sel <= synth_serial_pkg::RESYNC_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign frac_word_o = state_reg.frac_word;
   assign div_word_o = state_reg.div_word;
   assign ctrl_word_o = state_reg.ctrl_word;
   assign ref_word_o = state_reg.ref_word;
   assign fraction_denominator_o = state_reg.denom;
   assign realign_mult_o = state_reg.mult;
   assign realign_count_o = state_reg.count_sel;
   assign sync_pulse_o = state_reg.sync_pulse;
   assign realign_pulse_o = state_reg.realign_pulse;
endmodule

// *** hdl/synth_serial_pkg.sv ***
// Constants for the serial programming port and phase resync timer.
// Assumes a 100 MHz system clock that oversamples the serial pins.
package synth_serial_pkg;
   localparam int WORD_W = 24;
   localparam int ADDR_W = 2;
   localparam logic [1:0] ADDR_FRAC = 2'h0;
   localparam logic [1:0] ADDR_DIV = 2'h1;
   localparam logic [1:0] ADDR_CTRL = 2'h2;
   localparam logic [1:0] ADDR_REF = 2'h3;
   localparam int DIV_LSB = 2;
   localparam int DIV_W = 12;
   localparam int LOAD_CTRL_BIT = 23;
   localparam int RESYNC_LSB = 12;
   localparam int RESYNC_W = 4;
   localparam logic [11:0] DIV_RESET = 12'h000;
   localparam logic [3:0] RESYNC_RESET = 4'h0;
   localparam int SYNC_PULSE_TO_USE = 2;
endpackage

// *** sim/serial_host.sv ***
// Host model that writes words over the three-wire serial port.
// Pins change on the system clock edge; serial clock rests low.
`timescale 1ns/10ps
module serial_host (
   input wire logic sys_clk_i, // System clock.
   output logic sclk_o, // Serial clock.
   output logic sdata_o, // Serial data.
   output logic strobe_o // Load strobe.
);
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      strobe_o = 1'b0;
   end
   // Halves of five cycles give 10 MHz, below the top rate.
   task automatic send(input logic [23:0] w);
      @(posedge sys_clk_i) strobe_o <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdata_o <= w[i];
         repeat (5) @(posedge sys_clk_i);
         sclk_o <= 1'b1;
         repeat (5) @(posedge sys_clk_i);
         sclk_o <= 1'b0;
      end
      repeat (5) @(posedge sys_clk_i);
      strobe_o <= 1'b1;
      sdata_o <= ~w[0];
   endtask
endmodule

// *** sim/synth_serial_chk.sv ***
// Port assertions for the serial port and resync timer.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module synth_serial_chk #(parameter int WORD_W = 24) (
   input wire logic sys_clk_i, resetn_i, serial_clk_i, serial_data_i, load_strobe_i, ref_clk_i,
   input wire logic [WORD_W-1:0] frac_word_o, div_word_o, ctrl_word_o, ref_word_o,
   input wire logic [11:0] fraction_denominator_o, realign_mult_o,
   input wire logic [3:0] realign_count_o,
   input wire logic sync_pulse_o, realign_pulse_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   a_zero_count_quiet: assert property (realign_count_o == 4'h0 |-> !sync_pulse_o)
      else $error("sync with zero count");
   a_realign_on_sync: assert property (realign_pulse_o |-> sync_pulse_o)
      else $error("realign without sync");
   a_sync_single: assert property (sync_pulse_o |=> !sync_pulse_o)
      else $error("sync too long");
   a_sync_after_ref: assert property (sync_pulse_o |-> $past(ref_clk_i, 2))
      else $error("sync without reference");
   a_count_field: assert property ($changed(ctrl_word_o) |->
      ##[0:1] realign_count_o == ctrl_word_o[15:12]) else $error("count field");
   a_mult_route: assert property ($changed(realign_mult_o) |->
      ##[0:1] div_word_o[23] && realign_mult_o == div_word_o[13:2]) else $error("mult route");
   a_denom_route: assert property ($changed(fraction_denominator_o) |->
      ##[0:1] !div_word_o[23] && fraction_denominator_o == div_word_o[13:2])
      else $error("denominator route");
   a_load_on_strobe: assert property ($changed(frac_word_o) |-> $past(load_strobe_i, 2))
      else $error("load without strobe");
   c_sync: cover property (sync_pulse_o);
   c_realign: cover property (realign_pulse_o);
   c_mult: cover property ($changed(realign_mult_o));
endmodule
bind synth_serial_load_phase_resync synth_serial_chk #(.WORD_W(WORD_W)) u_synth_serial_chk (.*);

// *** sim/synth_serial_load_phase_resync_tb_top.sv ***
// Self-checking bench for the serial port and resync timer.
// Uses the host model and a free-running reference pin.
`timescale 1ns/10ps
module synth_serial_load_phase_resync_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic rclk = 1'b0;
   logic sclk, sdata, stb, sp, rp;
   logic [23:0] fw, dw, cw, rw;
   logic [11:0] den, mult;
   logic [3:0] cnt;
   int num_errors = 0;
   int tests_run = 0;
   int n_sync = 0;
   int n_re = 0;
   initial forever #5 clk = ~clk;
   // Offset by 1 ns so that no reference edge lands on a system clock edge.
   initial begin
      #1;
      forever #62.5 rclk = ~rclk;
   end
   serial_host u_serial_host (.sys_clk_i(clk), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(stb));
   synth_serial_load_phase_resync u_synth_serial_load_phase_resync (.sys_clk_i(clk),
      .resetn_i(rstn), .serial_clk_i(sclk), .serial_data_i(sdata), .load_strobe_i(stb),
      .ref_clk_i(rclk), .frac_word_o(fw), .div_word_o(dw), .ctrl_word_o(cw), .ref_word_o(rw),
      .fraction_denominator_o(den), .realign_mult_o(mult), .realign_count_o(cnt),
      .sync_pulse_o(sp), .realign_pulse_o(rp));
   always @(posedge clk) begin
      if (sp === 1'b1) n_sync++;
      if (rp === 1'b1) n_re++;
   end
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [23:0] w, input int wait_cycles);
      u_serial_host.send(w);
      repeat (5) @(posedge clk);
      @(negedge clk);
      n_sync = 0;
      n_re = 0;
      repeat (wait_cycles) @(posedge clk);
      // Compare away from the edge that updates the outputs and counters.
      @(negedge clk);
   endtask
   initial begin
      #200us;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check("reset count", 24'(cnt), 24'h0);
      check("reset den", 24'(den), 24'(synth_serial_pkg::DIV_RESET));
      check("reset syncs", 24'(n_sync), 24'h0);
      wr({1'b0, 9'h000, 12'h002, 2'h1}, 1);
      check("div", dw, {1'b0, 9'h000, 12'h002, 2'h1});
      check("den", 24'(den), 24'h2);
      check("mult", 24'(mult), 24'h0);
      wr({1'b1, 9'h000, 12'h002, 2'h1}, 1);
      check("mult", 24'(mult), 24'h2);
      check("den", 24'(den), 24'h2);
      wr({8'h00, 4'h1, 10'h000, 2'h2}, 1);
      check("ctrl", cw, {8'h00, 4'h1, 10'h000, 2'h2});
      check("count", 24'(cnt), 24'h1);
      wr({22'h2a5a5a, 2'h3}, 1);
      check("ref", rw, {22'h2a5a5a, 2'h3});
      check("frac kept", fw, 24'h0);
      // Count one times multiplier two: pulses on reference edges two and four.
      // Four reference periods stand in for the loop lock time here.
      wr({22'h012345, 2'h0}, 56);
      check("frac", fw, {22'h012345, 2'h0});
      check("syncs", 24'(n_sync), 24'h2);
      check("realigns", 24'(n_re), 24'h1);
      wr({8'h00, 4'h0, 10'h000, 2'h2}, 520);
      check("idle syncs", 24'(n_sync), 24'h0);
      check("idle realigns", 24'(n_re), 24'h0);
      report_and_stop();
   end
endmodule
